// *** logic/adcrr_regs.v ***
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "adcrr_map.vh"
module adcrr_regs #(
  parameter RES_W = 12
) (
  // Clock, reset, enable
  input  wire               sys_clk,
  input  wire               srst,
  input  wire               clk_en,
  // AXI4-Lite write address
  input  wire [11:0]        s_axi_awaddr,
  input  wire               s_axi_awvalid,
  output wire               s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]        s_axi_wdata,
  input  wire [3:0]         s_axi_wstrb,
  input  wire               s_axi_wvalid,
  output wire               s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]         s_axi_bresp,
  output reg                s_axi_bvalid,
  input  wire               s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0]        s_axi_araddr,
  input  wire               s_axi_arvalid,
  output wire               s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]        s_axi_rdata,
  output reg  [1:0]         s_axi_rresp,
  output reg                s_axi_rvalid,
  input  wire               s_axi_rready,
  // Conversion results, one strobe per channel 5..7
  input  wire [3*RES_W-1:0] conv_result,
  input  wire [2:0]         conv_valid,
  // RMS engine
  input  wire [15:0]        rms_value,
  input  wire               rms_sample,
  output wire [3:0]         rms_channel_select,
  output wire               rms_dc_removal,
  output wire [1:0]         rms_sample_count,
  output reg                rms_done,
  // Alert flags and output triggers
  input  wire [7:0]         alert_flags,
  output reg                digital_output_zero_trig,
  output reg                digital_output_one_trig
);

  // ===================================================
  // Registers
  reg  [7:0]  root_mean_square_config_ff;
  reg  [7:0]  trig0_ff;
  reg  [7:0]  trig1_ff;
  reg  [15:0] rms_res_ff;
  reg  [15:0] last_res_ff [0:2];
  reg  [16:0] smp_cnt_ff;
  reg  [11:0] aw_addr_ff;
  reg         aw_have_ff;
  reg  [31:0] w_data_ff;
  reg  [3:0]  w_strb_ff;
  reg         w_have_ff;
  reg  [7:0]  nxt_rdata;
  reg         nxt_rhit;
  wire [16:0] smp_target;
  wire        wr_fire;
  wire [7:0]  wr_byte;
  integer     i;
  // Channels 5..7 held in this slice
  localparam  NUM_CH = 3;
  // Next values, one per register that the bus, RMS window or trigger logic moves
  reg  [7:0]  nxt_root_mean_square_config;
  reg  [7:0]  nxt_trig0;
  reg  [7:0]  nxt_trig1;
  reg  [1:0]  nxt_bresp;
  reg  [1:0]  nxt_rresp;
  reg  [16:0] nxt_smp_cnt;
  reg  [15:0] nxt_rms_res;
  reg         nxt_rms_done;
  reg         nxt_trig_zero;
  reg         nxt_trig_one;
  reg  [7:0]  alert_prev_ff;
  // Handshake strobes, write lane, window end and alert rise
  wire        aw_take;
  wire        w_take;
  wire        b_take;
  wire        ar_take;
  wire        r_take;
  wire        wr_lane0;
  wire        smp_last;
  wire [7:0]  alert_rise;

  // ===================================================
  // Helpers
  function [7:0] word_idx;
    input [11:0] addr;
    begin
      word_idx = addr[9:2];
    end
  endfunction

  function [16:0] smp_total;
    input [1:0] code;
    begin
      // 1024 shifted left by two per code step
      smp_total = (`ADCRR_SMP_BASE << {code, 1'b0}) + `ADCRR_SMP_EXTRA;
    end
  endfunction

  assign rms_channel_select = root_mean_square_config_ff[`ADCRR_CFG_CHID_HI:`ADCRR_CFG_CHID_LO];
  assign rms_dc_removal     = root_mean_square_config_ff[`ADCRR_CFG_DCSUB];
  assign rms_sample_count   = root_mean_square_config_ff[`ADCRR_CFG_SMP_HI:`ADCRR_CFG_SMP_LO];
  assign smp_target         = smp_total(rms_sample_count);

  // ===================================================
  // Write channel: address and data taken in either order
  // Ready is gated by the clock enable: while the block is
  // frozen nothing could be stored, so nothing is accepted.
  assign s_axi_awready = clk_en & ~aw_have_ff & ~s_axi_bvalid;
  assign s_axi_wready  = clk_en & ~w_have_ff & ~s_axi_bvalid;
  assign aw_take       = s_axi_awvalid & s_axi_awready;
  assign w_take        = s_axi_wvalid & s_axi_wready;
  assign b_take        = s_axi_bvalid & s_axi_bready;
  assign wr_fire       = aw_have_ff & w_have_ff & ~s_axi_bvalid;
  assign wr_byte       = w_data_ff[7:0];
  assign wr_lane0      = w_strb_ff[0];

  // Address and data holding; a take and a fire never meet,
  // since a holder that is full refuses the next item
  always @(posedge sys_clk) begin
    if (srst) begin
      aw_have_ff <= 1'b0;
      w_have_ff  <= 1'b0;
      aw_addr_ff <= 12'h000;
      w_data_ff  <= 32'h00000000;
      w_strb_ff  <= 4'h0;
    end else if (clk_en) begin
      if (aw_take) begin
        aw_have_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_ff <= 1'b0;
      end
      if (w_take) begin
        w_have_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_ff <= 1'b0;
      end
    end
  end

  // Write decode: next value of every writable register
  always @* begin
    nxt_root_mean_square_config = root_mean_square_config_ff;
    nxt_trig0   = trig0_ff;
    nxt_trig1   = trig1_ff;
    nxt_bresp   = `ADCRR_RESP_OKAY;
    case (word_idx(aw_addr_ff))
      `ADCRR_IDX_ROOT_MEAN_SQUARE_CONFIG: begin
        // Reserved bit is masked off so it never stores
        if (wr_lane0)
          nxt_root_mean_square_config = wr_byte & `ADCRR_CFG_WMASK;
      end
      `ADCRR_IDX_TRIG0: begin
        if (wr_lane0)
          nxt_trig0 = wr_byte;
      end
      `ADCRR_IDX_TRIG1: begin
        if (wr_lane0)
          nxt_trig1 = wr_byte;
      end
      `ADCRR_IDX_CH5_LO, `ADCRR_IDX_CH5_HI, `ADCRR_IDX_CH6_LO,
      `ADCRR_IDX_CH6_HI, `ADCRR_IDX_CH7_LO, `ADCRR_IDX_CH7_HI,
      `ADCRR_IDX_RMS_LO, `ADCRR_IDX_RMS_HI: begin
        // Read-only: write is dropped, answered OKAY
        nxt_bresp = `ADCRR_RESP_OKAY;
      end
      default: begin
        nxt_bresp = `ADCRR_RESP_SLVERR;
      end
    endcase
  end

  // Register storage and write response
  always @(posedge sys_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ADCRR_RESP_OKAY;
      root_mean_square_config_ff   <= `ADCRR_RST_CFG;
      trig0_ff     <= `ADCRR_RST_TRIG;
      trig1_ff     <= `ADCRR_RST_TRIG;
    end else if (clk_en) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= nxt_bresp;
        root_mean_square_config_ff   <= nxt_root_mean_square_config;
        trig0_ff     <= nxt_trig0;
        trig1_ff     <= nxt_trig1;
      end else if (b_take) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ===================================================
  // Read decode
  always @* begin
    nxt_rdata = 8'h00;
    nxt_rhit  = 1'b1;
    case (word_idx(s_axi_araddr))
      `ADCRR_IDX_CH5_LO:  nxt_rdata = last_res_ff[0][7:0];
      `ADCRR_IDX_CH5_HI:  nxt_rdata = last_res_ff[0][15:8];
      `ADCRR_IDX_CH6_LO:  nxt_rdata = last_res_ff[1][7:0];
      `ADCRR_IDX_CH6_HI:  nxt_rdata = last_res_ff[1][15:8];
      `ADCRR_IDX_CH7_LO:  nxt_rdata = last_res_ff[2][7:0];
      `ADCRR_IDX_CH7_HI:  nxt_rdata = last_res_ff[2][15:8];
      `ADCRR_IDX_ROOT_MEAN_SQUARE_CONFIG: nxt_rdata = root_mean_square_config_ff & `ADCRR_CFG_WMASK;
      `ADCRR_IDX_RMS_LO:  nxt_rdata = rms_res_ff[7:0];
      `ADCRR_IDX_RMS_HI:  nxt_rdata = rms_res_ff[15:8];
      `ADCRR_IDX_TRIG0:   nxt_rdata = trig0_ff;
      `ADCRR_IDX_TRIG1:   nxt_rdata = trig1_ff;
      default:            nxt_rhit  = 1'b0;
    endcase
  end

  // ===================================================
  // Read response: data is registered when the address is
  // taken, so rdata stands unchanged until rready is seen
  assign s_axi_arready = clk_en & ~s_axi_rvalid;
  assign ar_take       = s_axi_arvalid & s_axi_arready;
  assign r_take        = s_axi_rvalid & s_axi_rready;

  always @* begin
    if (nxt_rhit)
      nxt_rresp = `ADCRR_RESP_OKAY;
    else
      nxt_rresp = `ADCRR_RESP_SLVERR;
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `ADCRR_RESP_OKAY;
    end else if (clk_en) begin
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, nxt_rdata};
        s_axi_rresp  <= nxt_rresp;
      end else if (r_take) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ===================================================
  // Latest conversion per channel, held MSB aligned so the
  // high byte is the first eight bits and the low byte the rest
  always @(posedge sys_clk) begin
    if (srst) begin
      for (i = 0; i < NUM_CH; i = i + 1)
        last_res_ff[i] <= 16'h0000;
    end else if (clk_en) begin
      for (i = 0; i < NUM_CH; i = i + 1)
        if (conv_valid[i])
          last_res_ff[i] <= {conv_result[i*RES_W +: RES_W],
                             {(16-RES_W){1'b0}}};
    end
  end

  // ===================================================
  // RMS window: count samples, latch the whole word at the end.
  // A config change does not restart the count; software that
  // changes the window mid-run sees one odd-length window.
  assign smp_last = (smp_cnt_ff + 17'h00001) >= smp_target;

  always @* begin
    nxt_smp_cnt  = smp_cnt_ff;
    nxt_rms_res  = rms_res_ff;
    nxt_rms_done = 1'b0;
    if (rms_sample) begin
      if (smp_last) begin
        nxt_smp_cnt  = 17'h00000;
        nxt_rms_res  = rms_value;
        nxt_rms_done = 1'b1;
      end else begin
        nxt_smp_cnt  = smp_cnt_ff + 17'h00001;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      smp_cnt_ff <= 17'h00000;
      rms_res_ff <= 16'h0000;
      rms_done   <= 1'b0;
    end else if (clk_en) begin
      smp_cnt_ff <= nxt_smp_cnt;
      rms_res_ff <= nxt_rms_res;
      rms_done   <= nxt_rms_done;
    end
  end

  // ===================================================
  // Event triggers: one-cycle pulse when any enabled alert rises.
  // The previous flags reset to the idle level, so a flag held
  // high through reset shows as a rise once reset ends.
  assign alert_rise = alert_flags & ~alert_prev_ff;

  always @* begin
    nxt_trig_zero = |(alert_rise & trig0_ff);
    nxt_trig_one  = |(alert_rise & trig1_ff);
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      alert_prev_ff            <= 8'h00;
      digital_output_zero_trig <= 1'b0;
      digital_output_one_trig  <= 1'b0;
    end else if (clk_en) begin
      alert_prev_ff            <= alert_flags;
      digital_output_zero_trig <= nxt_trig_zero;
      digital_output_one_trig  <= nxt_trig_one;
    end
  end

endmodule

// *** logic/adcrr_map.vh ***
`ifndef ADCRR_MAP_VH
`define ADCRR_MAP_VH
// =====================================================
// Register indices (byte address is four times these)
`define ADCRR_IDX_CH5_LO    8'haa
`define ADCRR_IDX_CH5_HI    8'hab
`define ADCRR_IDX_CH6_LO    8'hac
`define ADCRR_IDX_CH6_HI    8'had
`define ADCRR_IDX_CH7_LO    8'hae
`define ADCRR_IDX_CH7_HI    8'haf
`define ADCRR_IDX_ROOT_MEAN_SQUARE_CONFIG   8'hc0
`define ADCRR_IDX_RMS_LO    8'hc1
`define ADCRR_IDX_RMS_HI    8'hc2
`define ADCRR_IDX_TRIG0     8'hc3
`define ADCRR_IDX_TRIG1     8'hc5
// =====================================================
// Reset values and field positions
`define ADCRR_RST_CFG       8'h00
`define ADCRR_RST_TRIG      8'h02
`define ADCRR_CFG_WMASK     8'hf7
`define ADCRR_CFG_CHID_HI   7
`define ADCRR_CFG_CHID_LO   4
`define ADCRR_CFG_DCSUB     2
`define ADCRR_CFG_SMP_HI    1
`define ADCRR_CFG_SMP_LO    0
// =====================================================
// RMS window and bus response codes
`define ADCRR_SMP_BASE      17'h00400
`define ADCRR_SMP_EXTRA     17'h00028
`define ADCRR_RESP_OKAY     2'h0
`define ADCRR_RESP_SLVERR   2'h2
`endif

// *** bench/adcrr_regs_chk.sv ***
`timescale 1ns/1ps
`include "adcrr_map.vh"
module adcrr_chk (
  // Clock and reset
  input logic        sys_clk,
  input logic        srst,
  // Register bus
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] s_axi_rdata,
  // RMS and triggers
  input logic        rms_sample,
  input logic [1:0]  rms_sample_count,
  input logic [3:0]  rms_channel_select,
  input logic        rms_dc_removal,
  input logic        rms_done,
  input logic [7:0]  alert_flags,
  input logic        digital_output_zero_trig,
  input logic        digital_output_one_trig
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ==========================================
  // Sample tally; a config change does not restart it, as in the engine
  logic [16:0] smp_ff;
  wire  [16:0] smp_goal;
  wire  [6:0]  cfg_out;
  assign cfg_out = {rms_channel_select, rms_dc_removal, rms_sample_count};
  assign smp_goal = (`ADCRR_SMP_BASE << {rms_sample_count, 1'b0})
                  + `ADCRR_SMP_EXTRA;
  always_ff @(posedge sys_clk)
    if (srst || rms_done) smp_ff <= {16'h0, rms_sample};
    else smp_ff <= smp_ff + {16'h0, rms_sample};
  // ==========================================
  // Properties
  rms_when_a: assert property (rms_done |-> smp_ff == smp_goal)
    else $error("result latched at wrong sample count");
  rms_late_a: assert property (smp_ff <= smp_goal)
    else $error("sample window overran");
  rms_pulse_a: assert property (rms_done |=> !rms_done)
    else $error("done longer than one cycle");
  cfg_rst_a: assert property ($past(srst) |-> cfg_out == 7'h00)
    else $error("config not zero after reset");
  cfg_write_a: assert property ($changed(cfg_out) && !$past(srst)
    |-> ##[0:2] s_axi_bvalid) else $error("config moved without a write");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  w_resp_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("no write response");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  r_lat_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && s_axi_rdata[31:8] == 24'h0) else $error("bad read");
  trig0_a: assert property (digital_output_zero_trig |->
    |($past(alert_flags) & ~$past(alert_flags, 2))) else $error("stray trig0");
  trig1_a: assert property (digital_output_one_trig |->
    |($past(alert_flags) & ~$past(alert_flags, 2))) else $error("stray trig1");
endmodule
bind adcrr_regs adcrr_chk u_chk (.sys_clk, .srst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .rms_sample,
  .rms_sample_count, .rms_channel_select, .rms_dc_removal, .rms_done,
  .alert_flags, .digital_output_zero_trig, .digital_output_one_trig);

// *** bench/adcrr_regs_test.sv ***
`timescale 1ns/1ps
`include "adcrr_map.vh"
`define CMP(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module adcrr_regs_test;
  localparam [1:0] OK  = `ADCRR_RESP_OKAY;
  localparam [1:0] ERR = `ADCRR_RESP_SLVERR;
  reg         sys_clk = 0, srst = 1, clk_en = 1, rms_sample = 0;
  reg  [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  reg  [31:0] s_axi_wdata = 0;
  reg  [3:0]  s_axi_wstrb = 4'h1;
  reg         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  reg         s_axi_arvalid = 0, s_axi_rready = 0;
  reg  [35:0] conv_result = 0;
  reg  [2:0]  conv_valid = 0;
  reg  [15:0] rms_value = 0;
  reg  [7:0]  alert_flags = 0, v;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire        s_axi_rvalid, rms_dc_removal, rms_done;
  wire        digital_output_zero_trig, digital_output_one_trig;
  wire [1:0]  s_axi_bresp, s_axi_rresp, rms_sample_count;
  wire [3:0]  rms_channel_select;
  wire [31:0] s_axi_rdata;
  integer     fails = 0, checks = 0, dones = 0, t0 = 0, t1 = 0, k;
  adcrr_regs #(.RES_W(12)) uut (.sys_clk, .srst, .clk_en, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_result,
    .conv_valid, .rms_value, .rms_sample, .rms_channel_select,
    .rms_dc_removal, .rms_sample_count, .rms_done, .alert_flags,
    .digital_output_zero_trig, .digital_output_one_trig);
  always #4 sys_clk = ~sys_clk;
  // Pulses are tallied mid-cycle so the tally never races the bus tasks
  always @(negedge sys_clk) begin
    dones += rms_done;
    t0 += digital_output_zero_trig;
    t1 += digital_output_one_trig;
  end
  // ==========================================
  // Bus tasks
  task wr(input [7:0] i, input [7:0] d, input [1:0] r);
    @(posedge sys_clk);
    s_axi_awaddr <= {2'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    `CMP(s_axi_bresp, r)
  endtask
  task rd(input [7:0] i, input [7:0] d, input [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= {2'h0, i, 2'h0};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
    `CMP(s_axi_rdata, {24'h0, d})
    `CMP(s_axi_rresp, r)
  endtask
  task alert(input [7:0] f, input integer e0, input integer e1);
    @(posedge sys_clk);
    t0 = 0;
    t1 = 0;
    alert_flags <= f;
    repeat (4) @(posedge sys_clk);
    `CMP(t0, e0)
    `CMP(t1, e1)
  endtask
  task wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========================================
  // Tests
  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 0;
    for (k = 'haa; k <= 'hc2; k++) if (k < 'hb0 || k >= 'hc0) begin
      rd(k[7:0], 8'h00, OK);
    end
    rd(8'hc3, 8'h02, OK);
    rd(8'hc5, 8'h02, OK);
    rd(8'hc4, 8'h00, ERR);
    wr(8'hc4, 8'hff, ERR);
    conv_result <= 36'h5a7_123_abc;
    conv_valid <= 3'h7;
    @(posedge sys_clk);
    conv_valid <= 3'h0;
    rd(8'haa, 8'hc0, OK);
    rd(8'hab, 8'hab, OK);
    rd(8'hac, 8'h30, OK);
    rd(8'had, 8'h12, OK);
    rd(8'hae, 8'h70, OK);
    rd(8'haf, 8'h5a, OK);
    // A strobe while the clock enable is low must not land
    clk_en <= 0;
    conv_result <= 36'h0;
    conv_valid <= 3'h1;
    @(posedge sys_clk);
    conv_valid <= 3'h0;
    clk_en <= 1;
    rd(8'haa, 8'hc0, OK);
    rd(8'hab, 8'hab, OK);
    wr(8'hab, 8'h55, OK);
    rd(8'hab, 8'hab, OK);
    wr(8'hc0, 8'hff, OK);
    rd(8'hc0, 8'hf7, OK);
    for (k = 0; k < 4; k++) begin
      v = {k[3:0] + 4'h6, 1'b0, k[0], k[1:0]};
      wr(8'hc0, v, OK);
      `CMP(rms_channel_select, v[7:4])
      `CMP({rms_dc_removal, rms_sample_count}, v[2:0])
    end
    s_axi_wstrb <= 4'h0;
    wr(8'hc3, 8'hff, OK);
    s_axi_wstrb <= 4'h1;
    alert(8'h02, 1, 1);
    wr(8'hc3, 8'h81, OK);
    wr(8'hc5, 8'h04, OK);
    rd(8'hc3, 8'h81, OK);
    alert(8'h01, 1, 0);
    alert(8'h05, 0, 1);
    alert(8'h0d, 0, 0);
    alert(8'h8d, 1, 0);
    wr(8'hc0, 8'h00, OK);
    // Code 0: the window is 1024 plus the 40 settling samples
    @(posedge sys_clk);
    rms_value <= 16'h1234;
    rms_sample <= 1;
    repeat (1064) @(posedge sys_clk);
    `CMP(dones, 0)
    rms_sample <= 0;
    rms_value <= 16'hbeef;
    repeat (3) @(posedge sys_clk);
    `CMP(dones, 1)
    rd(8'hc1, 8'h34, OK);
    rd(8'hc2, 8'h12, OK);
    wrap_up;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    wrap_up;
  end
endmodule
